// ==== oms_pkg.sv ====
// Package with mode encodings and timing constants for the operating mode sequencer.
package oms_pkg;

  // ----------------------------------------
  // Mode encoding
  // ----------------------------------------
  typedef enum logic [5:0] {
    OMS_NOT_POWERED = 6'b00_0001,
    OMS_POWER_OFF   = 6'b00_0010,
    OMS_SWITCH_ON   = 6'b00_0100,
    OMS_ACTIVE      = 6'b00_1000,
    OMS_CONNECTED   = 6'b01_0000,
    OMS_IDLE        = 6'b10_0000
  } oms_mode_type;

  typedef enum logic [1:0] {
    OMS_SLP_NONE = 2'b01,
    OMS_SLP_DEEP = 2'b10
  } oms_sleep_type;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int OMS_CLK_HZ = 50_000_000;
  // Switch-on routine length in microseconds, and its cycle count.
  localparam int OMS_SWON_US = 10;
  localparam int OMS_SWON_CYC = (OMS_SWON_US * (OMS_CLK_HZ / 1_000_000));
  // Least low time of the wake/switch input that counts as a valid press.
  localparam int OMS_WAKE_US = 20;
  localparam int OMS_WAKE_CYC = (OMS_WAKE_US * (OMS_CLK_HZ / 1_000_000));
  // Least low time that counts as a switch-off press.
  localparam int OMS_OFF_US = 60;
  localparam int OMS_OFF_CYC = (OMS_OFF_US * (OMS_CLK_HZ / 1_000_000));
  // Extended DRX cycle threshold for deep sleep: 327.68 s in units of 10 ms.
  localparam logic [15:0] OMS_EDRX_DEEP_MIN = 16'h8000;
  localparam logic [11:0] OMS_CNT_RST = 12'h000;

endpackage

// ==== oms_sequencer.sv ====
// Operating mode sequencer: six operating modes, clock selection, interface and RF enables.
`timescale 1ns/1ps
module oms_sequencer
  import oms_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Supply and host pin
  input wire logic SUPPLY_OK,
  input wire logic WAKE_SWITCH_N,
  // Host commands, one-cycle pulses from the command decoder
  input wire logic LOW_POWER_CONFIG_CMD,
  input wire logic LOW_POWER_CONFIG_VAL,
  input wire logic PSM_SETTING_CMD,
  input wire logic PSM_SETTING_VAL,
  input wire logic EDRX_SETTING_CMD,
  input wire logic [15:0] EDRX_CYCLE,
  input wire logic SWITCH_OFF_CMD,
  // Modem status
  input wire logic LTE_ACTIVITY,
  input wire logic ACTIVITY_BUSY,
  input wire logic PAGING_TIME_WINDOW,
  input wire logic PERIODIC_TIMER_EXPIRED,
  // Mode outputs
  output oms_pkg::oms_mode_type MODE,
  output logic DEEP_SLEEP,
  output logic RTC_RUN,
  output logic CLK_32K_EN,
  output logic CLK_26M_EN,
  output logic CPU_RUN,
  output logic IF_ENABLE,
  output logic RF_ENABLE,
  output logic V_INT_ON,
  output logic LOW_POWER_EN
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic supply_s1_r, supply_r;
  logic wake_s1_r, wake_n_r;

  always_ff @(posedge MCLK) begin
    supply_s1_r <= SUPPLY_OK;
    supply_r <= supply_s1_r;
    wake_s1_r <= WAKE_SWITCH_N;
    wake_n_r <= wake_s1_r;
  end

  // ----------------------------------------
  // Wake/switch press measurement
  // ----------------------------------------
  // A press is classified at release so a long press is never mistaken for a short one.
  logic [11:0] low_cnt_r;
  logic [11:0] low_cnt_nxt;
  logic wake_prev_r;
  wire released = wake_n_r & ~wake_prev_r;
  wire short_press = released && (low_cnt_r >= 12'(OMS_WAKE_CYC)) && (low_cnt_r < 12'(OMS_OFF_CYC));
  wire long_press = released && (low_cnt_r >= 12'(OMS_OFF_CYC));
  assign low_cnt_nxt = wake_n_r ? OMS_CNT_RST : ((low_cnt_r == 12'hFFF) ? low_cnt_r : low_cnt_r + 12'h001);

  always_ff @(posedge MCLK) begin
    if (RST) begin
      low_cnt_r <= OMS_CNT_RST;
      wake_prev_r <= 1'b1;
    end else begin
      low_cnt_r <= low_cnt_nxt;
      wake_prev_r <= wake_n_r;
    end
  end

  // ----------------------------------------
  // Configuration held from host commands
  // ----------------------------------------
  logic lp_en_r, psm_en_r, edrx_long_r;
  oms_mode_type mode_r, mode_nxt;
  logic sleep_deep_r, sleep_deep_nxt;
  wire in_switch_on = (mode_r == OMS_SWITCH_ON);

  always_ff @(posedge MCLK) begin
    if (RST || in_switch_on) begin
      lp_en_r <= 1'b0;
      psm_en_r <= 1'b0;
      edrx_long_r <= 1'b0;
    end else begin
      if (LOW_POWER_CONFIG_CMD) lp_en_r <= LOW_POWER_CONFIG_VAL;
      if (PSM_SETTING_CMD) psm_en_r <= PSM_SETTING_VAL;
      if (EDRX_SETTING_CMD) edrx_long_r <= (EDRX_CYCLE >= OMS_EDRX_DEEP_MIN);
    end
  end

  // ----------------------------------------
  // Mode transitions
  // ----------------------------------------
  logic [11:0] swon_cnt_r;
  wire swon_done = (swon_cnt_r == 12'(OMS_SWON_CYC - 1));
  wire deep_ok = lp_en_r && !ACTIVITY_BUSY && (psm_en_r || (edrx_long_r && !PAGING_TIME_WINDOW));
  wire deep_wake = PERIODIC_TIMER_EXPIRED || PAGING_TIME_WINDOW || short_press;
  wire go_off = SWITCH_OFF_CMD || long_press;

  always_comb begin
    mode_nxt = mode_r;
    sleep_deep_nxt = sleep_deep_r;
    unique case (mode_r)
      OMS_NOT_POWERED: if (supply_r) mode_nxt = OMS_SWITCH_ON;
      OMS_POWER_OFF: if (short_press || long_press) mode_nxt = OMS_SWITCH_ON;
      OMS_SWITCH_ON: if (swon_done) mode_nxt = OMS_ACTIVE;
      OMS_ACTIVE: begin
        if (go_off) mode_nxt = OMS_POWER_OFF;
        else if (LTE_ACTIVITY) mode_nxt = OMS_CONNECTED;
        else if (lp_en_r && !ACTIVITY_BUSY) begin
          mode_nxt = OMS_IDLE;
          sleep_deep_nxt = deep_ok;
        end
      end
      OMS_CONNECTED: begin
        if (go_off) mode_nxt = OMS_POWER_OFF;
        else if (!LTE_ACTIVITY) mode_nxt = OMS_ACTIVE;
      end
      OMS_IDLE: begin
        if (sleep_deep_r) begin
          if (deep_wake) begin
            mode_nxt = OMS_ACTIVE;
            sleep_deep_nxt = 1'b0;
          end
        end else if (go_off) mode_nxt = OMS_POWER_OFF;
        else if (LTE_ACTIVITY || ACTIVITY_BUSY || !lp_en_r || short_press) mode_nxt = OMS_ACTIVE;
        else if (deep_ok) sleep_deep_nxt = 1'b1;
      end
      default: mode_nxt = OMS_NOT_POWERED;
    endcase
    if (!supply_r) begin
      mode_nxt = OMS_NOT_POWERED;
      sleep_deep_nxt = 1'b0;
    end
    if (mode_nxt != OMS_IDLE) sleep_deep_nxt = 1'b0;
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      mode_r <= OMS_NOT_POWERED;
      sleep_deep_r <= 1'b0;
      swon_cnt_r <= OMS_CNT_RST;
    end else begin
      mode_r <= mode_nxt;
      sleep_deep_r <= sleep_deep_nxt;
      swon_cnt_r <= in_switch_on ? swon_cnt_r + 12'h001 : OMS_CNT_RST;
    end
  end

  // ----------------------------------------
  // Output decode, registered
  // ----------------------------------------
  wire on_nxt = (mode_nxt == OMS_ACTIVE) || (mode_nxt == OMS_CONNECTED) || (mode_nxt == OMS_IDLE);
  wire deep_nxt = (mode_nxt == OMS_IDLE) && sleep_deep_nxt;
  wire fast_nxt = (mode_nxt == OMS_ACTIVE) || (mode_nxt == OMS_CONNECTED);
  wire slow_cpu_nxt = (mode_nxt == OMS_IDLE) && !sleep_deep_nxt;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      MODE <= OMS_NOT_POWERED;
      DEEP_SLEEP <= 1'b0;
      RTC_RUN <= 1'b0;
      CLK_32K_EN <= 1'b0;
      CLK_26M_EN <= 1'b0;
      CPU_RUN <= 1'b0;
      IF_ENABLE <= 1'b0;
      RF_ENABLE <= 1'b0;
      V_INT_ON <= 1'b0;
      LOW_POWER_EN <= 1'b0;
    end else begin
      MODE <= mode_nxt;
      DEEP_SLEEP <= deep_nxt;
      RTC_RUN <= on_nxt;
      CLK_32K_EN <= (mode_nxt == OMS_IDLE);
      CLK_26M_EN <= fast_nxt;
      CPU_RUN <= fast_nxt || slow_cpu_nxt;
      IF_ENABLE <= on_nxt && !deep_nxt;
      RF_ENABLE <= (mode_nxt == OMS_CONNECTED);
      V_INT_ON <= on_nxt && !deep_nxt;
      LOW_POWER_EN <= lp_en_r;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_supply_drop;
    !supply_r;
  endsequence

  sequence s_reach_off;
    ##1 (mode_r == OMS_NOT_POWERED);
  endsequence

  supply_loss_a: assert property (@(posedge MCLK) disable iff (RST) s_supply_drop |-> s_reach_off)
    else $error("Supply loss did not force not-powered mode.");
  swon_active_a: assert property (@(posedge MCLK) disable iff (RST)
    $rose(in_switch_on) && supply_r |-> ##[1:600] (mode_r == OMS_ACTIVE) || !supply_r)
    else $error("Switch-on routine did not reach active mode.");
  deep_clocks_a: assert property (@(posedge MCLK) disable iff (RST)
    DEEP_SLEEP |-> CLK_32K_EN && !CLK_26M_EN && !CPU_RUN)
    else $error("Deep-sleep clocking wrong.");
  idle_clock_a: assert property (@(posedge MCLK) disable iff (RST)
    (MODE == OMS_IDLE) && CPU_RUN |-> CLK_32K_EN && !CLK_26M_EN)
    else $error("Idle processor not on slow clock.");
  active_clock_a: assert property (@(posedge MCLK) disable iff (RST)
    (MODE == OMS_ACTIVE) |-> CLK_26M_EN && IF_ENABLE && !RF_ENABLE)
    else $error("Active mode outputs wrong.");
  connected_rf_a: assert property (@(posedge MCLK) disable iff (RST)
    RF_ENABLE |-> (MODE == OMS_CONNECTED) && CLK_26M_EN)
    else $error("RF enabled outside connected mode.");
  lte_connect_a: assert property (@(posedge MCLK) disable iff (RST)
    (mode_r == OMS_ACTIVE) && LTE_ACTIVITY && supply_r && !go_off |=> (mode_r == OMS_CONNECTED))
    else $error("LTE activity did not enter connected mode.");
  lp_idle_a: assert property (@(posedge MCLK) disable iff (RST)
    (mode_r == OMS_IDLE) && ($past(mode_r) == OMS_ACTIVE) |-> $past(lp_en_r))
    else $error("Idle entered without low-power configuration.");
  deep_if_a: assert property (@(posedge MCLK) disable iff (RST)
    DEEP_SLEEP |-> !IF_ENABLE && !V_INT_ON)
    else $error("Interfaces alive in deep-sleep.");
  switch_off_a: assert property (@(posedge MCLK) disable iff (RST)
    SWITCH_OFF_CMD && supply_r && ((mode_r == OMS_ACTIVE) || (mode_r == OMS_CONNECTED)) |=>
    (mode_r == OMS_POWER_OFF))
    else $error("Switch-off command ignored.");
  lp_clear_a: assert property (@(posedge MCLK) disable iff (RST)
    $fell(in_switch_on) |-> !lp_en_r)
    else $error("Low-power configuration survived switch-on.");

endmodule

// ==== oms_host.sv ====
// Host model that drives the wake/switch pin of the sequencer.
`timescale 1ns/1ps
module oms_host (
  // Clock
  input wire logic clk,
  // Host pin
  output logic wake_switch_n
);
  // A released pin rests at the pull-up level.
  initial wake_switch_n = 1'b1;
  task automatic press(input int cyc);
    @(posedge clk);
    wake_switch_n <= 1'b0;
    repeat (cyc) @(posedge clk);
    wake_switch_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule

// ==== oms_sequencer_bench.sv ====
// Self-checking bench for the operating mode sequencer.
`timescale 1ns/1ps
module oms_sequencer_bench;
  import oms_pkg::*;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic SUPPLY_OK = 1'b0;
  logic WAKE_SWITCH_N;
  logic [4:0] cmd = 5'h00;
  logic lp_val = 1'b0, psm_val = 1'b0, lte = 1'b0, busy = 1'b0, paging_time_window = 1'b0;
  logic [15:0] edrx = 16'h0000;
  oms_mode_type MODE;
  logic DEEP_SLEEP, RTC_RUN, CLK_32K_EN, CLK_26M_EN, CPU_RUN, IF_ENABLE, RF_ENABLE, V_INT_ON, LOW_POWER_EN;
  logic [8:0] outs;
  int fails = 0;
  int n_checks = 0;
  assign outs = {DEEP_SLEEP, RTC_RUN, CLK_32K_EN, CLK_26M_EN, CPU_RUN, IF_ENABLE, RF_ENABLE, V_INT_ON, LOW_POWER_EN};
  always #10 MCLK = ~MCLK;
  oms_host u_oms_host (.clk(MCLK), .wake_switch_n(WAKE_SWITCH_N));
  oms_sequencer u_oms_sequencer (.MCLK(MCLK), .RST(RST), .SUPPLY_OK(SUPPLY_OK), .WAKE_SWITCH_N(WAKE_SWITCH_N),
    .LOW_POWER_CONFIG_CMD(cmd[0]), .LOW_POWER_CONFIG_VAL(lp_val), .PSM_SETTING_CMD(cmd[1]),
    .PSM_SETTING_VAL(psm_val), .EDRX_SETTING_CMD(cmd[2]), .EDRX_CYCLE(edrx), .SWITCH_OFF_CMD(cmd[3]),
    .LTE_ACTIVITY(lte), .ACTIVITY_BUSY(busy), .PAGING_TIME_WINDOW(paging_time_window), .PERIODIC_TIMER_EXPIRED(cmd[4]),
    .MODE(MODE), .DEEP_SLEEP(DEEP_SLEEP), .RTC_RUN(RTC_RUN), .CLK_32K_EN(CLK_32K_EN), .CLK_26M_EN(CLK_26M_EN),
    .CPU_RUN(CPU_RUN), .IF_ENABLE(IF_ENABLE), .RF_ENABLE(RF_ENABLE), .V_INT_ON(V_INT_ON),
    .LOW_POWER_EN(LOW_POWER_EN));
  // Output bits: deep, rtc, 32k, 26m, cpu, if, rf, vint, lp; masked bits are left open.
  task automatic chk_out(input logic [8:0] exp, input logic [8:0] mask);
    n_checks++;
    if ((outs & mask) !== exp) begin
      fails++;
      $display("[ERR] outputs expected %h seen %h", exp, outs & mask);
    end
  endtask
  task automatic chk_mode(input oms_mode_type exp);
    n_checks++;
    if (MODE !== exp) begin
      fails++;
      $display("[ERR] mode expected %h seen %h", exp, MODE);
    end
  endtask
  task automatic wait_mode(input oms_mode_type m, input logic ds, input int lim);
    int i;
    i = 0;
    while (!(MODE === m && DEEP_SLEEP === ds) && i < lim) begin
      @(posedge MCLK);
      #1;
      i++;
    end
    chk_mode(m);
  endtask
  task automatic pulse(input int b);
    @(posedge MCLK);
    cmd[b] <= 1'b1;
    @(posedge MCLK);
    cmd <= 5'h00;
  endtask
  task automatic t_reset();
    #1 chk_mode(OMS_NOT_POWERED);
    chk_out(9'h000, 9'h1FF);
  endtask
  task automatic t_power_up();
    @(posedge MCLK) SUPPLY_OK <= 1'b1;
    wait_mode(OMS_SWITCH_ON, 1'b0, 10);
    wait_mode(OMS_ACTIVE, 1'b0, 600);
    chk_out(9'h0BA, 9'h1BF);
  endtask
  task automatic t_connected();
    @(posedge MCLK) lte <= 1'b1;
    wait_mode(OMS_CONNECTED, 1'b0, 10);
    chk_out(9'h036, 9'h136);
    @(posedge MCLK) lte <= 1'b0;
    wait_mode(OMS_ACTIVE, 1'b0, 10);
  endtask
  task automatic t_idle();
    @(posedge MCLK) busy <= 1'b1;
    lp_val <= 1'b1;
    pulse(0);
    repeat (20) @(posedge MCLK);
    #1 chk_mode(OMS_ACTIVE);
    @(posedge MCLK) busy <= 1'b0;
    wait_mode(OMS_IDLE, 1'b0, 10);
    chk_out(9'h053, 9'h157);
  endtask
  task automatic t_psm();
    @(posedge MCLK) psm_val <= 1'b1;
    pulse(1);
    wait_mode(OMS_IDLE, 1'b1, 20);
    chk_out(9'h1C0, 9'h1FE);
    @(posedge MCLK) busy <= 1'b1;
    pulse(4);
    wait_mode(OMS_ACTIVE, 1'b0, 10);
    @(posedge MCLK) busy <= 1'b0;
    wait_mode(OMS_IDLE, 1'b1, 20);
    @(posedge MCLK) busy <= 1'b1;
    u_oms_host.press(1500);
    wait_mode(OMS_ACTIVE, 1'b0, 10);
    @(posedge MCLK) psm_val <= 1'b0;
    pulse(1);
  endtask
  task automatic t_edrx();
    @(posedge MCLK) edrx <= 16'h7FFF;
    pulse(2);
    @(posedge MCLK) busy <= 1'b0;
    wait_mode(OMS_IDLE, 1'b0, 20);
    repeat (30) @(posedge MCLK);
    #1 chk_out(9'h000, 9'h100);
    @(posedge MCLK) edrx <= 16'h8000;
    pulse(2);
    wait_mode(OMS_IDLE, 1'b1, 20);
    @(posedge MCLK) busy <= 1'b1;
    paging_time_window <= 1'b1;
    wait_mode(OMS_ACTIVE, 1'b0, 10);
    @(posedge MCLK) paging_time_window <= 1'b0;
  endtask
  task automatic t_idle_exit();
    @(posedge MCLK) edrx <= 16'h7FFF;
    pulse(2);
    @(posedge MCLK) busy <= 1'b0;
    wait_mode(OMS_IDLE, 1'b0, 20);
    @(posedge MCLK) lte <= 1'b1;
    wait_mode(OMS_CONNECTED, 1'b0, 10);
    @(posedge MCLK) lte <= 1'b0;
    wait_mode(OMS_IDLE, 1'b0, 10);
    @(posedge MCLK) lp_val <= 1'b0;
    pulse(0);
    wait_mode(OMS_ACTIVE, 1'b0, 10);
    chk_out(9'h0BA, 9'h1BF);
  endtask
  task automatic t_switch_off();
    pulse(3);
    wait_mode(OMS_POWER_OFF, 1'b0, 20);
    chk_out(9'h000, 9'h1FE);
    pulse(4);
    repeat (5) @(posedge MCLK);
    #1 chk_mode(OMS_POWER_OFF);
  endtask
  task automatic t_long_press();
    u_oms_host.press(3500);
    wait_mode(OMS_ACTIVE, 1'b0, 600);
    chk_out(9'h0BA, 9'h1BF);
    u_oms_host.press(3500);
    wait_mode(OMS_POWER_OFF, 1'b0, 10);
  endtask
  task automatic t_supply_loss();
    @(posedge MCLK) SUPPLY_OK <= 1'b0;
    wait_mode(OMS_NOT_POWERED, 1'b0, 10);
    chk_out(9'h000, 9'h1FE);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge MCLK);
    RST <= 1'b0;
    t_reset();
    t_power_up();
    t_connected();
    t_idle();
    t_psm();
    t_edrx();
    t_idle_exit();
    t_switch_off();
    t_long_press();
    t_supply_loss();
    test_done();
  end
  // The sequence needs about 9700 cycles; the limit leaves a wide margin.
  initial begin
    repeat (40000) @(posedge MCLK);
    fails++;
    test_done();
  end
endmodule
